// >>> rtl/bst_pkg.sv
// constants, encodings and state type of the boundary-scan test port
// assumes the tap top imports it whole; no clocks or logic live here
package bst_pkg;

    // ****************************************************************
    // register geometry
    // ****************************************************************
    localparam int          BST_IR_W       = 4;
    localparam int          BST_ID_W       = 32;
    localparam int          BST_BSR_LEN    = 112;
    localparam int          BST_PIN_CNT    = 37;   // three cells per pin, top cell spare
    localparam int          BST_SYNC_LEN   = 2;

    // ****************************************************************
    // instruction codes and reset values
    // ****************************************************************
    localparam logic [3:0]  BST_INS_EXTEST = 4'h0;
    localparam logic [3:0]  BST_INS_SAMPLE = 4'h1;
    localparam logic [3:0]  BST_INS_IDCODE = 4'h2;
    localparam logic [3:0]  BST_INS_HIGHZ  = 4'h9;
    localparam logic [3:0]  BST_INS_CLAMP  = 4'hC;
    localparam logic [3:0]  BST_INS_BYPASS = 4'hF;
    localparam logic [3:0]  BST_IR_CAPTURE = 4'h1;  // fixed 01 pattern in low bits
    localparam logic [31:0] BST_ID_DEFAULT = 32'h1234_5001; // arbitrary value, bit 0 set

    // ****************************************************************
    // tap controller states, gray along the usual walk
    // ****************************************************************
    typedef enum logic [3:0] {
        BST_TLR    = 4'h0,
        BST_RTI    = 4'h1,
        BST_SEL_DR = 4'h3,
        BST_CAP_DR = 4'h2,
        BST_SH_DR  = 4'h6,
        BST_EX1_DR = 4'h7,
        BST_UPD_DR = 4'h5,
        BST_PS_DR  = 4'h4,
        BST_EX2_DR = 4'hC,
        BST_SEL_IR = 4'hD,
        BST_CAP_IR = 4'hF,
        BST_SH_IR  = 4'hE,
        BST_EX1_IR = 4'hA,
        BST_UPD_IR = 4'hB,
        BST_PS_IR  = 4'h9,
        BST_EX2_IR = 4'h8
    } bst_state_type;

    // data register chosen by an instruction
    typedef enum logic [1:0] {
        BST_DR_BYP = 2'h0,
        BST_DR_ID  = 2'h1,
        BST_DR_BSR = 2'h2
    } bst_dr_type;

endpackage

// >>> rtl/bst_tap.sv
// boundary-scan test access port: tap controller, instruction and data registers, pad muxing
// assumes tck from the board tester, core pad signals on sys_clk, pads joined by the bench
`timescale 1ns/100ps
module bst_tap #(
    parameter logic [31:0] ID_VALUE  = bst_pkg::BST_ID_DEFAULT,  // arbitrary value
    parameter bit          USE_ID    = 1'b1
) (
    // system clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          resetn,
    // test link, clocked by tck
    input  wire logic                          tck,
    input  wire logic                          trst_n,
    input  wire logic                          tms,
    input  wire logic                          tdi,
    output logic                               tdo_o,
    output logic                               tdo_oe,
    // core side of the pads
    input  wire logic [bst_pkg::BST_PIN_CNT-1:0] core_out,
    input  wire logic [bst_pkg::BST_PIN_CNT-1:0] core_oe,
    output logic      [bst_pkg::BST_PIN_CNT-1:0] core_in,
    // pad side
    input  wire logic [bst_pkg::BST_PIN_CNT-1:0] pad_i,
    output logic      [bst_pkg::BST_PIN_CNT-1:0] pad_o,
    output logic      [bst_pkg::BST_PIN_CNT-1:0] pad_oe
);
    import bst_pkg::*;

    localparam int P = BST_PIN_CNT;

    // ****************************************************************
    // decoding helpers
    // ****************************************************************
    // map an instruction onto the data register it selects
    function automatic bst_dr_type dr_of(input logic [3:0] ins);
        case (ins)
            BST_INS_EXTEST, BST_INS_SAMPLE: dr_of = BST_DR_BSR;
            BST_INS_IDCODE:                 dr_of = BST_DR_ID;
            default:                        dr_of = BST_DR_BYP;
        endcase
    endfunction

    // ****************************************************************
    // reset release, one synchroniser per domain
    // ****************************************************************
    logic rst_q1_ff, rst_q2_ff, trst_q1_ff, trst_q2_ff;
    wire  sys_rst_n = rst_q2_ff;
    wire  tap_rst_n = trst_q2_ff;   // test side never looks at system reset

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_q1_ff <= 1'b0;
            rst_q2_ff <= 1'b0;
        end else begin
            rst_q1_ff <= 1'b1;
            rst_q2_ff <= rst_q1_ff;
        end
    end

    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            trst_q1_ff <= 1'b0;
            trst_q2_ff <= 1'b0;
        end else begin
            trst_q1_ff <= 1'b1;
            trst_q2_ff <= trst_q1_ff;
        end
    end

    // ****************************************************************
    // tap controller
    // ****************************************************************
    bst_state_type state_ff, nxt_state;

    // sixteen-state walk steered by tms
    always_comb begin
        case (state_ff)
            BST_TLR:    nxt_state = tms ? BST_TLR    : BST_RTI;
            BST_RTI:    nxt_state = tms ? BST_SEL_DR : BST_RTI;
            BST_SEL_DR: nxt_state = tms ? BST_SEL_IR : BST_CAP_DR;
            BST_CAP_DR: nxt_state = tms ? BST_EX1_DR : BST_SH_DR;
            BST_SH_DR:  nxt_state = tms ? BST_EX1_DR : BST_SH_DR;
            BST_EX1_DR: nxt_state = tms ? BST_UPD_DR : BST_PS_DR;
            BST_PS_DR:  nxt_state = tms ? BST_EX2_DR : BST_PS_DR;
            BST_EX2_DR: nxt_state = tms ? BST_UPD_DR : BST_SH_DR;
            BST_UPD_DR: nxt_state = tms ? BST_SEL_DR : BST_RTI;
            BST_SEL_IR: nxt_state = tms ? BST_TLR    : BST_CAP_IR;
            BST_CAP_IR: nxt_state = tms ? BST_EX1_IR : BST_SH_IR;
            BST_SH_IR:  nxt_state = tms ? BST_EX1_IR : BST_SH_IR;
            BST_EX1_IR: nxt_state = tms ? BST_UPD_IR : BST_PS_IR;
            BST_PS_IR:  nxt_state = tms ? BST_EX2_IR : BST_PS_IR;
            BST_EX2_IR: nxt_state = tms ? BST_UPD_IR : BST_SH_IR;
            BST_UPD_IR: nxt_state = tms ? BST_SEL_DR : BST_RTI;
            default:    nxt_state = BST_TLR;
        endcase
    end

    // tms and tdi are sampled on the rising edge
    always_ff @(posedge tck or negedge tap_rst_n) begin
        if (!tap_rst_n) state_ff <= BST_TLR;
        else            state_ff <= nxt_state;
    end

    // ****************************************************************
    // instruction register
    // ****************************************************************
    localparam logic [3:0] RST_INS = USE_ID ? BST_INS_IDCODE : BST_INS_BYPASS;
    logic [BST_IR_W-1:0] ir_sh_ff, ir_ff;
    wire  bst_dr_type    dr_sel = dr_of(ir_ff);

    always_ff @(posedge tck or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            ir_sh_ff <= BST_IR_CAPTURE;
            ir_ff    <= RST_INS;
        end else begin
            if (state_ff == BST_CAP_IR)     ir_sh_ff <= BST_IR_CAPTURE;
            else if (state_ff == BST_SH_IR) ir_sh_ff <= {tdi, ir_sh_ff[BST_IR_W-1:1]};
            if (state_ff == BST_TLR)        ir_ff    <= RST_INS;
            else if (state_ff == BST_UPD_IR) ir_ff   <= ir_sh_ff;
        end
    end

    // ****************************************************************
    // pad states brought onto tck for capture
    // ****************************************************************
    logic [P-1:0] pin_t1_ff, pin_t2_ff, out_t1_ff, out_t2_ff, oe_t1_ff, oe_t2_ff;
    logic [BST_BSR_LEN-1:0] cap_vec;

    always_ff @(posedge tck or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            pin_t1_ff <= '0;
            pin_t2_ff <= '0;
            out_t1_ff <= '0;
            out_t2_ff <= '0;
            oe_t1_ff  <= '0;
            oe_t2_ff  <= '0;
        end else begin
            pin_t1_ff <= pad_i;
            pin_t2_ff <= pin_t1_ff;
            out_t1_ff <= pad_o;
            out_t2_ff <= out_t1_ff;
            oe_t1_ff  <= pad_oe;
            oe_t2_ff  <= oe_t1_ff;
        end
    end

    // three cells per pin: input, output data, output enable
    genvar k;
    generate
        for (k = 0; k < P; k++) begin : g_cell
            assign cap_vec[3*k]   = pin_t2_ff[k];
            assign cap_vec[3*k+1] = out_t2_ff[k];
            assign cap_vec[3*k+2] = oe_t2_ff[k];
        end
    endgenerate
    assign cap_vec[BST_BSR_LEN-1] = 1'b0;   // spare cell

    // ****************************************************************
    // data registers: bypass, identification, boundary
    // ****************************************************************
    logic                   byp_ff;
    logic [BST_ID_W-1:0]    id_ff;
    logic [BST_BSR_LEN-1:0] bsr_ff, upd_ff;
    wire  cap_dr = (state_ff == BST_CAP_DR);
    wire  sh_dr  = (state_ff == BST_SH_DR);

    always_ff @(posedge tck or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            byp_ff <= 1'b0;
            id_ff  <= '0;
            bsr_ff <= '0;
            upd_ff <= '0;
        end else begin
            if (dr_sel == BST_DR_BYP && cap_dr)     byp_ff <= 1'b0;
            else if (dr_sel == BST_DR_BYP && sh_dr) byp_ff <= tdi;
            if (dr_sel == BST_DR_ID && cap_dr)      id_ff  <= ID_VALUE;
            else if (dr_sel == BST_DR_ID && sh_dr)  id_ff  <= {tdi, id_ff[BST_ID_W-1:1]};
            // sample and external test both capture live pins
            if (dr_sel == BST_DR_BSR && cap_dr)     bsr_ff <= cap_vec;
            else if (dr_sel == BST_DR_BSR && sh_dr) bsr_ff <= {tdi, bsr_ff[BST_BSR_LEN-1:1]};
            // update also serves as preload for clamp
            if (dr_sel == BST_DR_BSR && state_ff == BST_UPD_DR) upd_ff <= bsr_ff;
        end
    end

    // ****************************************************************
    // serial output, changed on the falling edge
    // ****************************************************************
    wire nxt_tdo = (state_ff == BST_SH_IR) ? ir_sh_ff[0] :
                   (dr_sel == BST_DR_BSR)  ? bsr_ff[0]   :
                   (dr_sel == BST_DR_ID)   ? id_ff[0]    : byp_ff;
    wire nxt_tdo_oe = (state_ff == BST_SH_IR) || sh_dr;

    always_ff @(negedge tck or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            tdo_o  <= 1'b0;
            tdo_oe <= 1'b0;
        end else begin
            tdo_o  <= nxt_tdo;
            tdo_oe <= nxt_tdo_oe;
        end
    end

    // ****************************************************************
    // pad muxing on sys_clk; quasi-static test levels cross by two flops
    // ****************************************************************
    wire tst_drive = (ir_ff == BST_INS_EXTEST) || (ir_ff == BST_INS_CLAMP);
    wire tst_hiz   = (ir_ff == BST_INS_HIGHZ);
    logic [P-1:0] uo_s1_ff, uo_s2_ff, ue_s1_ff, ue_s2_ff, in_s1_ff;
    logic         drv_s1_ff, drv_s2_ff, hiz_s1_ff, hiz_s2_ff;
    wire  [P-1:0] upd_out, upd_oe;

    generate
        for (k = 0; k < P; k++) begin : g_upd
            assign upd_out[k] = upd_ff[3*k+1];
            assign upd_oe[k]  = upd_ff[3*k+2];
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            {uo_s1_ff, uo_s2_ff, ue_s1_ff, ue_s2_ff} <= '0;
            {drv_s1_ff, drv_s2_ff, hiz_s1_ff, hiz_s2_ff} <= '0;
            in_s1_ff <= '0;
            core_in  <= '0;
            pad_o    <= '0;
            pad_oe   <= '0;
        end else begin
            uo_s1_ff  <= upd_out;
            uo_s2_ff  <= uo_s1_ff;
            ue_s1_ff  <= upd_oe;
            ue_s2_ff  <= ue_s1_ff;
            drv_s1_ff <= tst_drive;
            drv_s2_ff <= drv_s1_ff;
            hiz_s1_ff <= tst_hiz;
            hiz_s2_ff <= hiz_s1_ff;
            in_s1_ff  <= pad_i;
            core_in   <= in_s1_ff;
            // boundary drives pins in external test and clamp
            pad_o     <= drv_s2_ff ? uo_s2_ff : core_out;
            // all drivers off under high impedance
            pad_oe    <= hiz_s2_ff ? '0 : (drv_s2_ff ? ue_s2_ff : core_oe);
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_five_ones;
        tms [*5];
    endsequence

    sequence s_byp_shift;
        (dr_sel == BST_DR_BYP) && sh_dr;
    endsequence

    chk_tlr_five_ones: assert property (@(posedge tck) disable iff (!tap_rst_n)
        s_five_ones |=> state_ff == BST_TLR)
        else $error("five tms highs did not reach reset state");

    chk_bypass_one_bit: assert property (@(posedge tck) disable iff (!tap_rst_n)
        s_byp_shift |=> byp_ff == $past(tdi))
        else $error("bypass stage did not hold last tdi");

    chk_bypass_capture: assert property (@(posedge tck) disable iff (!tap_rst_n)
        (dr_sel == BST_DR_BYP) && cap_dr |=> !byp_ff)
        else $error("bypass capture not zero");

    chk_id_shift_out: assert property (@(posedge tck) disable iff (!tap_rst_n)
        (dr_sel == BST_DR_ID) && cap_dr ##1 sh_dr |-> id_ff == ID_VALUE)
        else $error("identification value not captured");

    chk_bsr_shift_path: assert property (@(posedge tck) disable iff (!tap_rst_n)
        (dr_sel == BST_DR_BSR) && sh_dr |=>
            bsr_ff == {$past(tdi), $past(bsr_ff[BST_BSR_LEN-1:1])})
        else $error("boundary chain did not shift by one");

    chk_reset_ins: assert property (@(posedge tck) disable iff (!tap_rst_n)
        state_ff == BST_TLR |=> ir_ff == RST_INS)
        else $error("reset state did not load default instruction");

    chk_tdo_falling: assert property (@(negedge tck) disable iff (!tap_rst_n)
        1'b1 |=> tdo_oe == $past(nxt_tdo_oe))
        else $error("tdo enable not updated on falling edge");

    chk_highz_off: assert property (@(posedge sys_clk) disable iff (!sys_rst_n)
        hiz_s2_ff |=> pad_oe == '0)
        else $error("pad driver left on under high impedance");

    chk_sample_pins: assert property (@(posedge sys_clk) disable iff (!sys_rst_n)
        !drv_s2_ff && !hiz_s2_ff |=> pad_o == $past(core_out) && pad_oe == $past(core_oe))
        else $error("pins disturbed outside driving instructions");

    chk_clamp_drive: assert property (@(posedge sys_clk) disable iff (!sys_rst_n)
        drv_s2_ff && !hiz_s2_ff |=> pad_o == $past(uo_s2_ff))
        else $error("preloaded level not driven");

endmodule

// >>> sim/bst_tester.sv
// board test controller model: makes tck, drives trst_n, tms and tdi, collects tdo
// assumes the tap samples tms/tdi on the tck rise and updates tdo on the tck fall
`timescale 1ns/100ps
module bst_tester (
    // scan pins
    output logic         tck,
    output logic         trst_n,
    output logic         tms,
    output logic         tdi,
    input  wire logic    tdo_o,
    // collected shift result, bits beyond the length are zero
    output logic         res_stb,
    output logic [127:0] res_data
);
    // ****************************************************************
    // link driver, tck stands low between frames
    // ****************************************************************
    initial begin
        tck      = 1'b0;
        trst_n   = 1'b0;
        tms      = 1'b1;
        tdi      = 1'b0;
        res_stb  = 1'b0;
        res_data = '0;
    end

    // one 6 ns tck period: inputs change just after the fall, tdo taken at the rise
    task automatic step(input logic t, input logic d, output logic o);
        tms = t;
        tdi = d;
        #3;
        tck = 1'b1;
        o   = tdo_o;
        #3;
        tck = 1'b0;
    endtask

    // hard reset through trst_n, or seven rises with tms high; ends in idle
    task automatic tap_reset(input bit hard);
        logic o;
        trst_n = !hard;
        repeat (2) step(1'b1, 1'b0, o);
        trst_n = 1'b1;
        repeat (5) step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        tdi = ~tdi;  // released line shows the inverse of its last value
    endtask

    // full ir or dr scan from idle back to idle, lsb first
    task automatic shift(input bit ir, input int len, input logic [127:0] din);
        logic         o;
        logic [127:0] acc;
        acc = '0;
        step(1'b1, 1'b0, o);
        if (ir) begin
            step(1'b1, 1'b0, o);
        end
        step(1'b0, 1'b0, o);
        step(1'b0, 1'b0, o);
        for (int i = 0; i < len; i++) begin
            step(i == len - 1, din[i], acc[i]);
        end
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        tdi      = ~tdi;
        res_data = acc;
        res_stb  = 1'b1;
        #1;
        res_stb  = 1'b0;
    endtask
endmodule

// >>> sim/tb.sv
// self-checking bench of the boundary-scan port: scans through the tester model, checks pads
// assumes bst_pkg and bst_tap from rtl/, the tester model from sim/
`timescale 1ns/100ps
module tb;
    import bst_pkg::*;
    localparam logic [31:0] ID_VAL = 32'h5A3C_0F1B;  // arbitrary value, bit 0 set
    localparam int          NP     = BST_PIN_CNT;
    logic          sys_clk, resetn, tck, trst_n, tms, tdi, tdo_o, tdo_oe, res_stb;
    logic [127:0]  res_data, d;
    logic [NP-1:0] core_out, core_oe, core_in, pad_i, pad_o, pad_oe, co, coe, pi;
    logic [111:0]  pre;
    logic [127:0]  exp_q[$];
    logic [3:0]    byp_codes[4] = '{BST_INS_BYPASS, 4'h5, 4'h7, 4'hA};
    int            num_errors, check_count;

    bst_tap #(.ID_VALUE(ID_VAL), .USE_ID(1'b1)) i_bst_tap (
        .sys_clk(sys_clk), .resetn(resetn), .tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi),
        .tdo_o(tdo_o), .tdo_oe(tdo_oe), .core_out(core_out), .core_oe(core_oe), .core_in(core_in),
        .pad_i(pad_i), .pad_o(pad_o), .pad_oe(pad_oe));
    bst_tester i_bst_tester (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo_o(tdo_o),
        .res_stb(res_stb), .res_data(res_data));

    initial sys_clk = 1'b0;
    always #25 sys_clk = ~sys_clk;

    // ****************************************************************
    // comparison, scoreboard and helpers
    // ****************************************************************
    task automatic cmp(input logic [127:0] got, input logic [127:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_pad(input logic [NP-1:0] got, input logic [NP-1:0] exp);
        cmp(128'(got), 128'(exp));
    endtask

    // oldest expected scan result against each result the tester hands back
    always @(posedge res_stb) begin
        cmp(res_data, exp_q.pop_front());
    end

    // note the expectation, run the scan, tdo driver must be off afterwards
    task automatic scan(input bit ir, input int len, input logic [127:0] din, input logic [127:0] exp);
        exp_q.push_back(exp);
        i_bst_tester.shift(ir, len, din);
        cmp(128'(tdo_oe), '0);
    endtask

    function automatic logic [127:0] rnd();
        return {$urandom, $urandom, $urandom, $urandom};
    endfunction

    // cells of one kind (0 pin in, 1 drive value, 2 drive enable) out of a 112-bit image
    function automatic logic [NP-1:0] pick(input logic [111:0] v, input int off);
        for (int k = 0; k < NP; k++) begin
            pick[k] = v[3*k+off];
        end
    endfunction

    function automatic logic [127:0] bsr_exp(input logic [NP-1:0] i, input logic [NP-1:0] o,
                                             input logic [NP-1:0] e);
        bsr_exp = '0;
        for (int k = 0; k < NP; k++) begin
            bsr_exp[3*k+:3] = {e[k], o[k], i[k]};
        end
    endfunction

    // new core and pin levels at the sys_clk fall, then let them settle
    task automatic drive();
        d  = rnd();
        co = d[NP-1:0];
        coe = d[NP+:NP];
        pi = d[2*NP+:NP];
        @(negedge sys_clk);
        core_out = co;
        core_oe  = coe;
        pad_i    = pi;
        repeat (6) @(negedge sys_clk);
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #200000;
        num_errors++;
        tally_and_finish();
    end

    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial begin
        void'($urandom(89775));
        resetn = 1'b0;
        core_out = '0;
        core_oe = '0;
        pad_i = '0;
        num_errors = 0;
        check_count = 0;
        repeat (8) @(negedge sys_clk);
        resetn = 1'b1;
        i_bst_tester.tap_reset(1'b1);
        scan(0, 32, rnd(), 128'(ID_VAL));
        drive();
        cmp_pad(pad_o, co);
        cmp_pad(core_in, pi);
        // sample: capture live pins, preload the update cells, pads untouched
        scan(1, 4, 128'(BST_INS_SAMPLE), 128'(BST_IR_CAPTURE));
        d = rnd();
        pre = d[111:0];
        scan(0, 112, d, bsr_exp(pi, co, coe));
        cmp_pad(pad_o, co);
        // clamp: preloaded levels hold while the core moves, bypass stage selected
        scan(1, 4, 128'(BST_INS_CLAMP), 128'(BST_IR_CAPTURE));
        drive();
        cmp_pad(pad_o, pick(pre, 1));
        cmp_pad(pad_oe, pick(pre, 2));
        d = rnd();
        scan(0, 8, d, 128'({d[6:0], 1'b0}));
        // external test: pads from the update cells, capture of pins, new update
        scan(1, 4, 128'(BST_INS_EXTEST), 128'(BST_IR_CAPTURE));
        drive();
        cmp_pad(pad_o, pick(pre, 1));
        d = rnd();
        scan(0, 112, d, bsr_exp(pi, pick(pre, 1), pick(pre, 2)));
        repeat (6) @(negedge sys_clk);
        cmp_pad(pad_o, pick(d[111:0], 1));
        cmp_pad(pad_oe, pick(d[111:0], 2));
        // high impedance: every driver off
        scan(1, 4, 128'(BST_INS_HIGHZ), 128'(BST_IR_CAPTURE));
        repeat (6) @(negedge sys_clk);
        cmp_pad(pad_oe, '0);
        // bypass and unknown codes give a one-bit path
        foreach (byp_codes[j]) begin
            scan(1, 4, 128'(byp_codes[j]), 128'(BST_IR_CAPTURE));
            d = rnd();
            scan(0, 8, d, 128'({d[6:0], 1'b0}));
        end
        // tms reset while the system is held in reset; scan still works
        @(negedge sys_clk);
        resetn = 1'b0;
        i_bst_tester.tap_reset(1'b0);
        scan(0, 32, rnd(), 128'(ID_VAL));
        // system reset keeps pads and core inputs low while the scan runs
        cmp_pad(pad_o, '0);
        cmp_pad(pad_oe, '0);
        cmp_pad(core_in, '0);
        @(negedge sys_clk);
        resetn = 1'b1;
        drive();
        cmp_pad(pad_o, co);
        cmp_pad(pad_oe, coe);
        tally_and_finish();
    end
endmodule
